//--- adc_out_params.svh
`ifndef ADC_OUT_PARAMS_SVH
`define ADC_OUT_PARAMS_SVH

// ----------------------------------------
// Pipeline and word layout
// ----------------------------------------
`define DATA_W 12
`define PIPE_DEPTH 8
`define STAGE_W 4

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define CTRL_ADDR 4'h0
`define STATUS_ADDR 4'h4
`define LATENCY_ADDR 4'h8

// ----------------------------------------
// Control field positions and reset value
// ----------------------------------------
`define CTRL_OE_N_BIT 0
`define CTRL_GRAY_BIT 1
`define CTRL_TWOS_BIT 2
`define CTRL_PWR_LSB 3
`define CTRL_RESET 32'h0000_0000

// ----------------------------------------
// Power state codes
// ----------------------------------------
`define PWR_NORMAL 2'h0
`define PWR_STANDBY 2'h1
`define PWR_DOWN 2'h2

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- adc_out_pkg.sv
package adc_out_pkg;
	`include "adc_out_params.svh"

	typedef struct packed {
		logic [`DATA_W-1:0] code;
		logic range_flag;
	} sample_t;

	typedef struct packed {
		logic [1:0] power_state;
		logic twos_select;
		logic gray_code_select;
		logic oe_n;
	} ctrl_t;

	typedef struct packed {
		logic aw_busy;
		logic [3:0] aw_addr;
		logic w_busy;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bus_t;
endpackage

//--- adc_output_stage.sv
`timescale 1ns/100ps
`include "adc_out_params.svh"

// How it works
// - Each result leaves the pipe exactly eight clock cycles after its sample entered.
// - The output word changes only on a rising clock edge, or when reset clears it.
// - The range flag travels in the same pipe slot as its data word.
// - The flag is low for in-range samples and high for out-of-range ones.
// - The flag stays high until an in-range sample has itself reached the output.
// - With the output disable low and the power state normal the data pins are driven.
// - With the output disable high the data pins float.
// - The output disable resets low so the outputs start enabled.
// - The data word is twelve bits wide.
// - Gray select gives gray code, otherwise the format bit picks offset binary or twos.
// - Standby and power-down float the outputs whatever the output disable says.
module adc_output_stage
	import adc_out_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic [`DATA_W-1:0] SAMPLE_CODE,
	input wire logic SAMPLE_OVER,
	input wire logic SAMPLE_UNDER,
	output logic [`DATA_W-1:0] DATA_OUT,
	output logic [`DATA_W-1:0] DATA_OE_N,
	output logic OUT_OF_RANGE_FLAG,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	typedef struct packed {
		sample_t [`PIPE_DEPTH-1:0] pipe;
		sample_t out;
		logic [`DATA_W-1:0] oe_n;
		ctrl_t ctrl;
		bus_t bus;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic [`DATA_W-1:0] fmt;
	logic floating;
	logic [31:0] ctrl_word;

	// ----------------------------------------
	// Output formatting
	// ----------------------------------------
	always_comb begin
		ctrl_word = {27'h0, s_q.ctrl};
		// Converter core delivers offset binary
		fmt = s_q.pipe[`PIPE_DEPTH-1].code;
		if (s_q.ctrl.gray_code_select) begin
			fmt = fmt ^ (fmt >> 1);
		end else if (s_q.ctrl.twos_select) begin
			fmt[`DATA_W-1] = ~fmt[`DATA_W-1];
		end
		floating = s_q.ctrl.oe_n || (s_q.ctrl.power_state != `PWR_NORMAL);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		// Shift every cycle; no stall exists
		s_d.pipe[0].range_flag = SAMPLE_OVER || SAMPLE_UNDER;
		// Clamp to the end code the receiver expects for the flag
		s_d.pipe[0].code = SAMPLE_OVER ? 12'hFFF : (SAMPLE_UNDER ? 12'h000 : SAMPLE_CODE);
		for (int i = 1; i < `PIPE_DEPTH; i++) begin
			s_d.pipe[i] = s_q.pipe[i-1];
		end
		// Output latch changes eight edges after the taking edge
		// Input capture counts as no cycle, like the analog hold
		s_d.out.code = fmt;
		s_d.out.range_flag = s_q.pipe[`PIPE_DEPTH-1].range_flag;
		s_d.oe_n = {`DATA_W{floating}};
		// Write channels taken in either order
		if (S_AXI_AWVALID && !s_q.bus.aw_busy) begin
			s_d.bus.aw_busy = 1'b1;
			s_d.bus.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !s_q.bus.w_busy) begin
			s_d.bus.w_busy = 1'b1;
			s_d.bus.w_data = S_AXI_WDATA;
			s_d.bus.w_strb = S_AXI_WSTRB;
		end
		if (s_q.bus.aw_busy && s_q.bus.w_busy && !s_q.bus.bvalid) begin
			s_d.bus.bvalid = 1'b1;
			s_d.bus.bresp = `RESP_OKAY;
			if (s_q.bus.aw_addr == `CTRL_ADDR) begin
				if (s_q.bus.w_strb[0]) begin
					s_d.ctrl = ctrl_t'(s_q.bus.w_data[4:0]);
				end
			end else if (s_q.bus.aw_addr != `STATUS_ADDR && s_q.bus.aw_addr != `LATENCY_ADDR) begin
				s_d.bus.bresp = `RESP_SLVERR;
			end
		end
		if (s_q.bus.bvalid && S_AXI_BREADY) begin
			s_d.bus.bvalid = 1'b0;
			s_d.bus.aw_busy = 1'b0;
			s_d.bus.w_busy = 1'b0;
		end
		if (S_AXI_ARVALID && !s_q.bus.rvalid) begin
			s_d.bus.rvalid = 1'b1;
			s_d.bus.rresp = `RESP_OKAY;
			case (S_AXI_ARADDR)
				`CTRL_ADDR: s_d.bus.rdata = ctrl_word;
				`STATUS_ADDR: s_d.bus.rdata = {19'h0, s_q.out.range_flag, s_q.out.code};
				`LATENCY_ADDR: s_d.bus.rdata = 32'(`PIPE_DEPTH);
				default: begin
					s_d.bus.rdata = 32'h0000_0000;
					s_d.bus.rresp = `RESP_SLVERR;
				end
			endcase
		end else if (s_q.bus.rvalid && S_AXI_RREADY) begin
			s_d.bus.rvalid = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q <= '0;
			s_q.ctrl <= ctrl_t'(5'(`CTRL_RESET));
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Ports, all from flops
	// ----------------------------------------
	always_comb begin
		DATA_OUT = s_q.out.code;
		DATA_OE_N = s_q.oe_n;
		OUT_OF_RANGE_FLAG = s_q.out.range_flag;
		S_AXI_AWREADY = !s_q.bus.aw_busy;
		S_AXI_WREADY = !s_q.bus.w_busy;
		S_AXI_BVALID = s_q.bus.bvalid;
		S_AXI_BRESP = s_q.bus.bresp;
		S_AXI_ARREADY = !s_q.bus.rvalid;
		S_AXI_RVALID = s_q.bus.rvalid;
		S_AXI_RDATA = s_q.bus.rdata;
		S_AXI_RRESP = s_q.bus.rresp;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_flag_latency;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		##9 (OUT_OF_RANGE_FLAG == $past(SAMPLE_OVER || SAMPLE_UNDER, 9));
	endproperty
	a_flag_latency: assert property (p_flag_latency) else $error("flag latency wrong");

	property p_over_code;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(SAMPLE_OVER && !SAMPLE_UNDER) |-> ##9 (OUT_OF_RANGE_FLAG && DATA_OUT != 12'h000);
	endproperty
	a_over_code: assert property (p_over_code) else $error("overrange word wrong");

	property p_in_range;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!SAMPLE_OVER && !SAMPLE_UNDER) [*2] |-> ##8 !OUT_OF_RANGE_FLAG;
	endproperty
	a_in_range: assert property (p_in_range) else $error("flag high in range");

	property p_flag_hold;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		$fell(OUT_OF_RANGE_FLAG) |-> !$past(SAMPLE_OVER || SAMPLE_UNDER, 9);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped early");

	property p_drive;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!s_q.ctrl.oe_n && s_q.ctrl.power_state == `PWR_NORMAL) |=> (DATA_OE_N == 12'h000);
	endproperty
	a_drive: assert property (p_drive) else $error("outputs not driven");

	property p_float;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		s_q.ctrl.oe_n |=> (DATA_OE_N == 12'hFFF);
	endproperty
	a_float: assert property (p_float) else $error("outputs not floating");

	property p_power_float;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(s_q.ctrl.power_state != `PWR_NORMAL) |=> (DATA_OE_N == 12'hFFF);
	endproperty
	a_power_float: assert property (p_power_float) else $error("outputs driven in low power");

	property p_gray;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		s_q.ctrl.gray_code_select |=>
		(DATA_OUT == ($past(s_q.pipe[7].code) ^ ($past(s_q.pipe[7].code) >> 1)));
	endproperty
	a_gray: assert property (p_gray) else $error("gray code wrong");

	property p_stream;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		##1 (s_q.pipe[1] == $past(s_q.pipe[0]));
	endproperty
	a_stream: assert property (p_stream) else $error("pipe stalled");

endmodule

//--- capture_model.sv
`timescale 1ns/100ps
`include "adc_out_params.svh"
// ------
// Receiver
// ------
module capture_model (
	input wire logic clk,
	input wire logic [`DATA_W-1:0] data,
	input wire logic [`DATA_W-1:0] oe_n,
	input wire logic flag,
	output logic [`DATA_W-1:0] pin,
	output logic [1:0] cls
);
	logic [`DATA_W-1:0] last = '0;
	// Floating pins show the inverse of the last level, never a held value
	assign pin = (data & ~oe_n) | (~last & oe_n);
	always @(posedge clk) last <= pin;
	assign cls = !flag ? 2'h0 : (pin[`DATA_W-1] ? 2'h2 : 2'h1);
endmodule

//--- adc_output_range_flag_and_enable_bench.sv
`timescale 1ns/100ps
`include "adc_out_params.svh"
`define CHK(nm,e,s) begin samples_checked++; if ((e)!==(s)) begin n_errors++; \
	$display("[FAIL] %s exp %h got %h", nm, e, s); end end
// ------
// Bench
// ------
module adc_output_range_flag_and_enable_bench import adc_out_pkg::*;;
	logic clk = 0, rst_n = 0, ov = 0, un = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [11:0] code = 0, dout, oen, pin;
	logic [3:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd, rdata;
	logic [1:0] rsp, cls, bresp, rresp;
	logic flg, awr, wr_r, bv, arr, rv;
	logic [12:0] q[$];
	logic [4:0] fm[4] = '{5'h00, 5'h02, 5'h04, 5'h06};
	logic [4:0] ov_set[4] = '{5'h01, 5'h08, 5'h10, 5'h00};
	int n_errors = 0, samples_checked = 0;
	initial forever #50 clk = ~clk;
	adc_output_stage dut_u (.CLK_SYS(clk), .RESET_N(rst_n), .SAMPLE_CODE(code),
		.SAMPLE_OVER(ov), .SAMPLE_UNDER(un), .DATA_OUT(dout), .DATA_OE_N(oen),
		.OUT_OF_RANGE_FLAG(flg), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
	capture_model far_u (.clk(clk), .data(dout), .oe_n(oen), .flag(flg), .pin(pin), .cls(cls));
	task test_done;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task tmo(input int n);
		if (n >= 64) begin
			n_errors++;
			$display("[FAIL] wait exp done got timeout");
			test_done;
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ad, dd;
		n = 0; ad = 0; dd = 0;
		@(posedge clk);
		awa <= a; wd <= d; awv <= 1; wv <= 1;
		while (!(ad && dd) && n < 64) begin
			@(posedge clk); n++;
			if (!ad && awr) begin ad = 1; awv <= 0; end
			if (!dd && wr_r) begin dd = 1; wv <= 0; end
		end
		tmo(n); bre <= 1; n = 0;
		do begin @(posedge clk); n++; end while (!bv && n < 64);
		tmo(n); r = bresp; bre <= 0;
	endtask
	task rdt(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		ara <= a; arv <= 1;
		do begin @(posedge clk); n++; end while (!arr && n < 64);
		tmo(n); arv <= 0; rre <= 1; n = 0;
		do begin @(posedge clk); n++; end while (!rv && n < 64);
		tmo(n); d = rdata; r = rresp; rre <= 0;
	endtask
	// Model's own formatting: clamp, then gray wins over twos
	function logic [11:0] fmt(logic [11:0] c, logic o, logic u, logic [4:0] f);
		logic [11:0] b;
		b = o ? 12'hFFF : (u ? 12'h000 : c);
		if (f[`CTRL_GRAY_BIT]) return b ^ (b >> 1);
		if (f[`CTRL_TWOS_BIT]) return b ^ 12'h800;
		return b;
	endfunction
	task run(input logic [4:0] f);
		int r;
		logic [11:0] c;
		logic [12:0] e;
		q.delete();
		repeat (40) begin
			@(posedge clk);
			r = $urandom % 4; c = $urandom;
			ov <= r == 0; un <= r == 1; code <= c;
			q.push_back({r < 2, fmt(c, r == 0, r == 1, f)});
			@(negedge clk);
			if (q.size() == 10) begin
				e = q.pop_front();
				`CHK("data", e[11:0], dout)
				`CHK("flag", e[12], flg)
				`CHK("class", e[12] ? (e[11] ? 2'h2 : 2'h1) : 2'h0, cls)
			end
		end
	endtask
	initial begin
		void'($urandom(32'hC3A8));
		repeat (16) @(posedge clk);
		rst_n <= 1;
		@(negedge clk) `CHK("oe_rst", 12'h000, oen)
		rdt(`LATENCY_ADDR, rd, rsp); `CHK("latency", 32'h0000_0008, rd)
		rdt(4'hC, rd, rsp); `CHK("rd_unmapped", `RESP_SLVERR, rsp)
		wr(4'hC, 32'h1, rsp); `CHK("wr_unmapped", `RESP_SLVERR, rsp)
		$display("test regs done");
		foreach (fm[i]) begin
			wr(`CTRL_ADDR, fm[i], rsp); `CHK("wr_ok", `RESP_OKAY, rsp)
			run(fm[i]);
		end
		$display("test stream done");
		// Slow, widely spaced enable and power state changes only
		foreach (ov_set[i]) begin
			wr(`CTRL_ADDR, ov_set[i], rsp);
			rdt(`CTRL_ADDR, rd, rsp); `CHK("ctrl_rd", {27'h0, ov_set[i]}, rd)
			repeat (3) @(posedge clk);
			@(negedge clk) `CHK("oe", (ov_set[i] != 0) ? 12'hFFF : 12'h000, oen)
		end
		$display("test enable done");
		test_done;
	end
endmodule
